// ===== inc/csr_bridge_pkg.sv
// Constants shared by the indirect fabric register access bridge.
//==============================================================================
// Summary of operation
// - Data register targets the indexed fabric register
// - Data read returns fabric data or last write
// - Writing pending bit launches one fabric access
// - Pending stays set until access completes
// - Read data valid when pending clears
// - Direction bit: zero writes, one reads
// - Step-up data write launches, then increments index
// - Step-up data read increments index, launches read
// - Step-down data write launches, then decrements index
// - Step-down data read decrements index, launches read
// - Step-up wins over step-down
// - Lane select gates fabric write bytes
// - Low sixteen command bits hold target index
package csr_bridge_pkg;

  //==============================================================================
  // Register map.
  localparam int           ADDR_W          = 12;
  localparam logic [11:0]  DATA_OFFSET     = 12'h1ac;
  localparam logic [11:0]  CMD_OFFSET      = 12'h1b0;

  //==============================================================================
  // Command register field positions.
  localparam int           PENDING_BIT     = 31;
  localparam int           RNW_BIT         = 30;
  localparam int           STEP_UP_BIT     = 29;
  localparam int           STEP_DOWN_BIT   = 28;
  localparam int           LANE_LSB        = 16;
  localparam int           LANE_W          = 4;
  localparam int           INDEX_LSB       = 0;
  localparam int           INDEX_W         = 16;

  //==============================================================================
  // Reset values.
  localparam logic [31:0]  DATA_RESET      = 32'h0000_0000;
  localparam logic [3:0]   LANE_RESET      = 4'h0;
  localparam logic [15:0]  INDEX_RESET     = 16'h0000;
  localparam logic [15:0]  INDEX_ONE       = 16'h0001;

  //==============================================================================
  // AXI4-Lite response codes.
  localparam logic [1:0]   RESP_OKAY       = 2'h0;
  localparam logic [1:0]   RESP_SLVERR     = 2'h2;

endpackage : csr_bridge_pkg

// ===== inc/fabric_req_if.sv
// Request and answer bundle between the bridge registers and the fabric engine.
`timescale 1ns/1ps
interface fabric_req_if;
  logic        start;
  logic        write;
  logic [15:0] index;
  logic [3:0]  lanes;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;

  modport regs   (output start, write, index, lanes, wdata, input done, rdata);
  modport engine (input start, write, index, lanes, wdata, output done, rdata);
endinterface : fabric_req_if

// ===== hw/axil_write_join.sv
// Joins AXI4-Lite write address and write data that may arrive in either order.
`timescale 1ns/1ps
module axil_write_join
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic             pair_valid,
  output logic [11:0]      pair_addr,
  output logic [31:0]      pair_data,
  output logic [3:0]       pair_strb,
  input  wire logic        pair_take
);

  logic awready_reg;
  logic wready_reg;

  //==============================================================================
  // Each channel is held until the pair is consumed, which back-pressures the master.
  // Ready flags are flops of their own, so no gate follows them.
  assign awready    = awready_reg;
  assign wready     = wready_reg;
  assign pair_valid = ~awready_reg & ~wready_reg;

  // Address holding stage.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready_reg <= 1'b1;
      pair_addr   <= 12'h000;
    end
    else if (pair_take)
      awready_reg <= 1'b1;
    else if (awvalid && awready_reg)
    begin
      awready_reg <= 1'b0;
      pair_addr   <= awaddr;
    end
  end

  // Data holding stage.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wready_reg <= 1'b1;
      pair_data  <= 32'h0000_0000;
      pair_strb  <= 4'h0;
    end
    else if (pair_take)
      wready_reg <= 1'b1;
    else if (wvalid && wready_reg)
    begin
      wready_reg <= 1'b0;
      pair_data  <= wdata;
      pair_strb  <= wstrb;
    end
  end

endmodule : axil_write_join

// ===== hw/fabric_access_engine.sv
// Runs one fabric register access at a time with a request held until acknowledge.
`timescale 1ns/1ps
module fabric_access_engine
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  fabric_req_if.engine     req,
  output logic             fab_req,
  output logic             fab_write,
  output logic [15:0]      fab_index,
  output logic [3:0]       fab_lanes,
  output logic [31:0]      fab_wdata,
  input  wire logic        fab_ack,
  input  wire logic [31:0] fab_rdata
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } engine_state_t;

  engine_state_t state_reg;
  logic          done_reg;
  logic [31:0]   rdata_reg;

  assign req.done  = done_reg;
  assign req.rdata = rdata_reg;

  //==============================================================================
  // Sequencer: the request stays up until the fabric acknowledges it.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      fab_req   <= 1'b0;
      fab_write <= 1'b0;
      fab_index <= 16'h0000;
      fab_lanes <= 4'h0;
      fab_wdata <= 32'h0000_0000;
      done_reg  <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (req.start)
          begin
            state_reg <= ST_BUSY;
            fab_req   <= 1'b1;
            fab_write <= req.write;
            fab_index <= req.index;
            fab_lanes <= req.write ? req.lanes : 4'h0;
            fab_wdata <= req.wdata;
          end
        end
        ST_BUSY:
        begin
          if (fab_ack)
          begin
            state_reg <= ST_IDLE;
            fab_req   <= 1'b0;
            done_reg  <= 1'b1;
            if (!fab_write)
              rdata_reg <= fab_rdata;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          fab_req   <= 1'b0;
        end
      endcase
    end
  end

endmodule : fabric_access_engine

// ===== hw/switch_csr_indirect_access.sv
// Indirect data and command registers that reach the fabric register space over AXI4-Lite.
`timescale 1ns/1ps
module switch_csr_indirect_access
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             FAB_REQ,
  output logic             FAB_WRITE,
  output logic [15:0]      FAB_INDEX,
  output logic [3:0]       FAB_LANES,
  output logic [31:0]      FAB_WDATA,
  input  wire logic        FAB_ACK,
  input  wire logic [31:0] FAB_RDATA
);

  //==============================================================================
  // Helpers.

  // Selects register 0 (data) or 1 (command); bit 2 flags an unmapped address.
  // Only word addresses compare; the low two bits are ignored.
  function automatic logic [2:0] reg_select(input logic [11:0] addr);
    logic [2:0] sel;
    sel = 3'b100;
    if (addr[11:2] == csr_bridge_pkg::DATA_OFFSET[11:2])
      sel = 3'b001;
    else if (addr[11:2] == csr_bridge_pkg::CMD_OFFSET[11:2])
      sel = 3'b010;
    return sel;
  endfunction : reg_select

  // Merges a write into an old value under the byte strobes.
  // Shared by the data, command and fabric words.
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction : strobe_merge

  //==============================================================================
  // Declarations.

  // Register state.
  logic [31:0]  host_data_reg;
  logic [31:0]  fab_data_reg;
  logic         pending_reg;
  logic         rnw_reg;
  logic         step_up_reg;
  logic         step_down_reg;
  logic [3:0]   lanes_reg;
  logic [15:0]  index_reg;
  logic         post_step_reg;
  logic         post_up_reg;
  logic         bvalid_reg;
  logic [1:0]   bresp_reg;
  logic         arready_reg;
  logic         rvalid_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;

  // Decode of the current cycle.
  logic         pair_valid;
  logic [11:0]  pair_addr;
  logic [31:0]  pair_data;
  logic [3:0]   pair_strb;
  logic         pair_take;
  logic [2:0]   wsel;
  logic [2:0]   rsel;
  logic         ar_take;
  logic [31:0]  cmd_view;
  logic [31:0]  cmd_new;
  logic         wr_data_hit;
  logic         wr_cmd_hit;
  logic         rd_data_hit;
  logic         stepping;
  logic         wr_launch;
  logic         rd_launch;
  logic [15:0]  index_next;
  logic [15:0]  index_step;

  // One launch goes out, one done pulse comes back.
  fabric_req_if fab_if ();

  //==============================================================================
  // Bus front end.

  // Address and data may arrive in either order.
  axil_write_join u_write_join
  (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .awaddr     (S_AXI_AWADDR),
    .awvalid    (S_AXI_AWVALID),
    .awready    (S_AXI_AWREADY),
    .wdata      (S_AXI_WDATA),
    .wstrb      (S_AXI_WSTRB),
    .wvalid     (S_AXI_WVALID),
    .wready     (S_AXI_WREADY),
    .pair_valid (pair_valid),
    .pair_addr  (pair_addr),
    .pair_data  (pair_data),
    .pair_strb  (pair_strb),
    .pair_take  (pair_take)
  );

  // A pair is taken only when no write response is still outstanding.
  // At most one write is in flight.
  assign pair_take     = pair_valid & ~bvalid_reg;
  assign ar_take       = S_AXI_ARVALID & arready_reg;
  assign wsel          = reg_select(pair_addr);
  assign rsel          = reg_select(S_AXI_ARADDR);
  // Response outputs come straight from registers.
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

  // Live command view and its strobe-merged update.
  // Bits 27:20 read as zero and ignore writes.
  assign cmd_view = {pending_reg, rnw_reg, step_up_reg, step_down_reg, 8'h00, lanes_reg, index_reg};
  assign cmd_new  = strobe_merge(cmd_view, pair_data, pair_strb);

  //==============================================================================
  // Launch decisions; writes arriving while an access runs are dropped.
  // A dropped write still answers OKAY, so software
  // polls the pending bit instead.
  assign stepping    = step_up_reg | step_down_reg;
  assign wr_data_hit = pair_take & wsel[0] & ~pending_reg;
  assign wr_cmd_hit  = pair_take & wsel[1] & ~pending_reg;
  assign rd_data_hit = ar_take & rsel[0] & ~pending_reg;
  assign wr_launch   = (wr_cmd_hit & cmd_new[csr_bridge_pkg::PENDING_BIT]) | (wr_data_hit & stepping);
  // A read launch yields to a same-cycle write.
  assign rd_launch   = rd_data_hit & stepping & ~wr_launch & ~wr_cmd_hit;
  // Step-up takes precedence over step-down and the index wraps naturally.
  // Reads step at launch, writes at completion.
  assign index_step  = step_up_reg ? (index_reg + csr_bridge_pkg::INDEX_ONE)
                                   : (index_reg - csr_bridge_pkg::INDEX_ONE);
  assign index_next  = rd_launch ? index_step
                     : (wr_cmd_hit ? cmd_new[csr_bridge_pkg::INDEX_LSB +: csr_bridge_pkg::INDEX_W] : index_reg);

  // A launching command write uses its new fields.
  assign fab_if.start = wr_launch | rd_launch;
  assign fab_if.write = wr_cmd_hit ? ~cmd_new[csr_bridge_pkg::RNW_BIT] : ~rnw_reg;
  assign fab_if.index = index_next;
  assign fab_if.lanes = wr_cmd_hit ? cmd_new[csr_bridge_pkg::LANE_LSB +: csr_bridge_pkg::LANE_W] : lanes_reg;
  assign fab_if.wdata = wr_data_hit ? strobe_merge(host_data_reg, pair_data, pair_strb) : host_data_reg;

  // The engine holds the fabric fields stable.
  fabric_access_engine u_engine
  (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .req       (fab_if),
    .fab_req   (FAB_REQ),
    .fab_write (FAB_WRITE),
    .fab_index (FAB_INDEX),
    .fab_lanes (FAB_LANES),
    .fab_wdata (FAB_WDATA),
    .fab_ack   (FAB_ACK),
    .fab_rdata (FAB_RDATA)
  );

  //==============================================================================
  // Host data register keeps the last value software wrote.
  // Ignored while pending, so the word stays put.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      host_data_reg <= csr_bridge_pkg::DATA_RESET;
    else if (wr_data_hit)
      host_data_reg <= fab_if.wdata;
  end

  // Fabric read data is captured on completion, so it is ready when pending drops.
  // The done pulse follows acknowledge by one edge.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      fab_data_reg <= csr_bridge_pkg::DATA_RESET;
    else if (fab_if.done && !FAB_WRITE)
      fab_data_reg <= fab_if.rdata;
  end

  // Command fields, the pending flag and the index stepping.
  // The step direction is latched at launch, so the
  // completion step never depends on later bits.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pending_reg   <= 1'b0;
      rnw_reg       <= 1'b0;
      step_up_reg   <= 1'b0;
      step_down_reg <= 1'b0;
      lanes_reg     <= csr_bridge_pkg::LANE_RESET;
      index_reg     <= csr_bridge_pkg::INDEX_RESET;
      post_step_reg <= 1'b0;
      post_up_reg   <= 1'b0;
    end
    else
    begin
      if (wr_cmd_hit)
      begin
        rnw_reg       <= cmd_new[csr_bridge_pkg::RNW_BIT];
        step_up_reg   <= cmd_new[csr_bridge_pkg::STEP_UP_BIT];
        step_down_reg <= cmd_new[csr_bridge_pkg::STEP_DOWN_BIT];
        lanes_reg     <= cmd_new[csr_bridge_pkg::LANE_LSB +: csr_bridge_pkg::LANE_W];
      end
      // Command writes and stepping reads move it now.
      index_reg <= index_next;
      // Launch and done never share a cycle.
      if (fab_if.start)
      begin
        pending_reg   <= 1'b1;
        // Only a stepping data write moves the index after it completes.
        post_step_reg <= wr_data_hit & stepping;
        post_up_reg   <= step_up_reg;
      end
      else if (fab_if.done)
      begin
        pending_reg   <= 1'b0;
        post_step_reg <= 1'b0;
        if (post_step_reg)
          index_reg <= post_up_reg ? (index_reg + csr_bridge_pkg::INDEX_ONE)
                                   : (index_reg - csr_bridge_pkg::INDEX_ONE);
      end
    end
  end

  //==============================================================================
  // Write response channel; unmapped addresses answer with a slave error.
  // Responses appear one cycle after the pair.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= csr_bridge_pkg::RESP_OKAY;
    end
    else if (pair_take)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wsel[2] ? csr_bridge_pkg::RESP_SLVERR : csr_bridge_pkg::RESP_OKAY;
    end
    // A standing response is never overwritten.
    else if (S_AXI_BREADY)
      bvalid_reg <= 1'b0;
  end

  // Read channel: one read at a time, data sampled at address acceptance.
  // A stepping read returns the previous word, not
  // the one it launches, so a burst's first is stale.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= csr_bridge_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= rsel[2] ? csr_bridge_pkg::RESP_SLVERR : csr_bridge_pkg::RESP_OKAY;
      // Unmapped reads answer zero with an error.
      if (rsel[0])
        rdata_reg <= rnw_reg ? fab_data_reg : host_data_reg;
      else if (rsel[1])
        rdata_reg <= cmd_view;
      else
        rdata_reg <= 32'h0000_0000;
    end
    else if (rvalid_reg && S_AXI_RREADY)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
    // Ready returns once no response stands.
    else if (!rvalid_reg)
      arready_reg <= 1'b1;
  end

endmodule : switch_csr_indirect_access

// ===== sim/csr_bridge_asserts.sv
// Port-level assertions for the indirect fabric access bridge.
`timescale 1ns/1ps
module csr_bridge_asserts
(
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        FAB_REQ,
  input wire logic        FAB_WRITE,
  input wire logic [15:0] FAB_INDEX,
  input wire logic [3:0]  FAB_LANES,
  input wire logic [31:0] FAB_WDATA,
  input wire logic        FAB_ACK
);
  //============================================================================
  // Shared clocking and sequences.
  // One clock domain, so clocking and reset are given once for all checks.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  // An access ends at acknowledge; pending clears two edges later, so no relaunch may show before then.
  sequence s_ack;
    FAB_REQ && FAB_ACK;
  endsequence
  sequence s_quiet;
    !FAB_REQ [*2];
  endsequence

  //============================================================================
  // Fabric side.
  chk_req_holds: assert property (FAB_REQ && !FAB_ACK |=> FAB_REQ)
    else $error("fabric request dropped before acknowledge");
  chk_req_gap: assert property (s_ack |=> s_quiet)
    else $error("fabric request not retired after acknowledge");
  chk_fab_stable: assert property (FAB_REQ && !FAB_ACK |=> $stable({FAB_WRITE, FAB_INDEX, FAB_LANES, FAB_WDATA}))
    else $error("fabric request fields moved while waiting");
  chk_read_lanes: assert property (FAB_REQ && !FAB_WRITE |-> FAB_LANES == 4'h0)
    else $error("byte lanes offered on a fabric read");
  chk_launch_source: assert property ($rose(FAB_REQ) |-> $rose(S_AXI_BVALID) || $rose(S_AXI_RVALID))
    else $error("fabric access launched without a host access");

  //============================================================================
  // Register bus side.
  chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read not answered one cycle after address");
  chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data withdrawn before ready");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response withdrawn before ready");
endmodule : csr_bridge_asserts

bind switch_csr_indirect_access csr_bridge_asserts csr_bridge_asserts_inst
(
  .CLK(CLK), .RESET_N(RESET_N), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .FAB_REQ(FAB_REQ), .FAB_WRITE(FAB_WRITE), .FAB_INDEX(FAB_INDEX), .FAB_LANES(FAB_LANES),
  .FAB_WDATA(FAB_WDATA), .FAB_ACK(FAB_ACK)
);

// ===== sim/fabric_model.sv
// Behavioural fabric register space answering requests after a variable stall.
`timescale 1ns/1ps
module fabric_model
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        req,
  input  wire logic        slow,
  input  wire logic [15:0] index,
  output logic             ack,
  output logic [31:0]      rdata
);
  int seed = 65;
  int wait_n;

  //============================================================================
  // Answer engine.
  // Read data is valid only with ack; otherwise it changes every cycle, so a late sample is caught.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack    <= 1'b0;
      wait_n <= 0;
      rdata  <= 32'h0;
    end
    else
    begin
      ack   <= 1'b0;
      rdata <= $random(seed);
      if (!req)
        wait_n <= slow ? 20 : ($random(seed) & 3);
      else if (wait_n != 0)
        wait_n <= wait_n - 1;
      else if (!ack)
      begin
        ack   <= 1'b1;
        rdata <= {~index, index};
      end
    end
  end
endmodule : fabric_model

// ===== sim/tb.sv
// Self-checking bench for the indirect fabric access bridge.
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] DAT = csr_bridge_pkg::DATA_OFFSET;
  localparam logic [11:0] CMD = csr_bridge_pkg::CMD_OFFSET;
  localparam logic [1:0]  OK  = csr_bridge_pkg::RESP_OKAY;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, slow, fab_req_d;
  logic        awready, wready, bvalid, arready, rvalid, fab_req, fab_write, fab_ack;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d, last, rdata, fab_wdata, fab_rdata;
  logic [15:0] idx, fab_index;
  logic [3:0]  wstrb, fab_lanes;
  logic [1:0]  bresp, rresp;
  int          mismatches, checks, cycles, seed;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [52:0] fq[$];
  logic [31:0] sb[3] = '{32'h2000_0000, 32'h1000_0000, 32'h3000_0000};
  logic [15:0] si[3] = '{16'hffff, 16'h0000, 16'h1234};
  logic [15:0] sn[3] = '{16'h0000, 16'hffff, 16'h1235};

  switch_csr_indirect_access switch_csr_indirect_access_inst
  (
    .CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .FAB_REQ(fab_req), .FAB_WRITE(fab_write),
    .FAB_INDEX(fab_index), .FAB_LANES(fab_lanes), .FAB_WDATA(fab_wdata), .FAB_ACK(fab_ack), .FAB_RDATA(fab_rdata)
  );
  fabric_model fabric_model_inst
  (
    .clk(clk), .reset_n(rst_n), .req(fab_req), .slow(slow), .index(fab_index), .ack(fab_ack), .rdata(fab_rdata)
  );

  //============================================================================
  // Clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //============================================================================
  // Helpers.
  task check(input logic [52:0] seen, input logic [52:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Address and data go out together; ready is raised only once the response shows, so the hold path is used.
  task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clk);
    bq.push_back(r);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (ap || wp)
    begin
      @(posedge clk);
      if (ap && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge clk);
    rq.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  // Waits out the fabric access, then the two edges pending needs to clear.
  task wait_done;
    do @(posedge clk); while (fab_req !== 1'b0);
    repeat (2) @(posedge clk);
  endtask : wait_done

  //============================================================================
  // Monitor: each result seen is compared with the oldest note.
  always @(posedge clk)
  begin
    fab_req_d <= fab_req;
    if (rvalid && rready)
      check(53'({rresp, rdata}), 53'(rq.pop_front()));
    if (bvalid && bready)
      check(53'(bresp), 53'(bq.pop_front()));
    if (fab_req && !fab_req_d)
      check({fab_write, fab_index, fab_lanes, fab_write ? fab_wdata : 32'h0}, fq.pop_front());
  end

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  //============================================================================
  // Main sequence.
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hf;
    seed = 65;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(DAT, {OK, csr_bridge_pkg::DATA_RESET});
    rd(CMD, {OK, 32'h0});
    rd(12'h1b4, {csr_bridge_pkg::RESP_SLVERR, 32'h0});
    wr(12'h1b4, 32'h1, csr_bridge_pkg::RESP_SLVERR);
    $display("reset and unmapped test done");
    // Slow fabric write: pending must read set, and a data write meanwhile is dropped.
    d = $random(seed);
    idx = 16'($random(seed));
    slow <= 1'b1;
    wr(DAT, d, OK);
    fq.push_back({1'b1, idx, 4'ha, d});
    wr(CMD, 32'h800a_0000 | idx, OK);
    rd(CMD, {OK, 32'h800a_0000 | idx});
    wr(DAT, ~d, OK);
    wait_done();
    slow <= 1'b0;
    rd(DAT, {OK, d});
    rd(CMD, {OK, 32'h000a_0000 | idx});
    // Plain fabric read.
    idx = 16'($random(seed));
    fq.push_back({1'b0, idx, 4'h0, 32'h0});
    wr(CMD, 32'hc000_0000 | idx, OK);
    wait_done();
    rd(DAT, {OK, ~idx, idx});
    rd(CMD, {OK, 32'h4000_0000 | idx});
    last = {~idx, idx};
    $display("launch test done");
    // Stepping data writes: up and down across the index boundaries, then both set at 1234.
    for (int m = 0; m < 3; m++)
    begin
      wr(CMD, sb[m] | 32'h000f_0000 | si[m], OK);
      d = $random(seed);
      fq.push_back({1'b1, si[m], 4'hf, d});
      wr(DAT, d, OK);
      wait_done();
      rd(CMD, {OK, sb[m] | 32'h000f_0000 | sn[m]});
    end
    $display("stepping write test done");
    // Stepping data reads: index steps first, then the read is launched.
    for (int m = 0; m < 2; m++)
    begin
      wr(CMD, 32'h4000_0000 | sb[m] | si[m], OK);
      fq.push_back({1'b0, sn[m], 4'h0, 32'h0});
      rd(DAT, {OK, last});
      wait_done();
      rd(CMD, {OK, 32'h4000_0000 | sb[m] | sn[m]});
      wr(CMD, 32'h4000_0000 | sn[m], OK);
      rd(DAT, {OK, ~sn[m], sn[m]});
      last = {~sn[m], sn[m]};
    end
    // Partial strobes merge bytes into the held data word.
    wr(CMD, 32'h0, OK);
    wstrb <= 4'h3;
    wr(DAT, 32'h2222_2222, OK);
    wstrb <= 4'hf;
    rd(DAT, {OK, d[31:16], 16'h2222});
    $display("stepping read test done");
    finish_test();
  end
endmodule : tb
